// file: hdl/cgp_pkg.sv
package cgp_pkg;
  localparam int NUM_PINS = 20;
  localparam int NUM_SRC = 8;
  localparam int SRC_W = 3;
  // Drive mode codes
  localparam logic [2:0] DM_INPUT_ONLY = 3'h0;
  localparam logic [2:0] DM_WEAKUP_STRONGDN = 3'h1;
  localparam logic [2:0] DM_STRONGUP_WEAKDN = 3'h2;
  localparam logic [2:0] DM_OD_STRONGDN = 3'h3;
  localparam logic [2:0] DM_OD_STRONGUP = 3'h4;
  localparam logic [2:0] DM_STRONG = 3'h5;
  localparam logic [2:0] DM_WEAK = 3'h6;
  // Register byte offsets
  localparam logic [11:0] OFS_OUT = 12'h000;
  localparam logic [11:0] OFS_IN = 12'h004;
  localparam logic [11:0] OFS_INEN = 12'h008;
  localparam logic [11:0] OFS_OUTEN = 12'h00c;
  localparam logic [11:0] OFS_THR = 12'h010;
  localparam logic [11:0] OFS_SLEW = 12'h014;
  localparam logic [11:0] OFS_HOLD = 12'h018;
  localparam logic [11:0] OFS_AMUX = 12'h01c;
  localparam logic [11:0] OFS_I2C = 12'h020;
  localparam logic [11:0] OFS_MODE0 = 12'h040;
  localparam logic [11:0] OFS_SEL0 = 12'h0c0;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [2:0] RST_SEL = 3'h0;
endpackage

// file: hdl/cgp_cfg_mem.sv
`timescale 1ns/100ps
module cgp_cfg_mem
  import cgp_pkg::*;
#(
  parameter int DEPTH = 20,
  parameter int WIDTH = 3,
  parameter int AW = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata,
  output logic [DEPTH*WIDTH-1:0] all_q
);
  logic [DEPTH*WIDTH-1:0] mem_d;
  logic [WIDTH-1:0] rd_d;

  always_comb begin
    mem_d = all_q;
    if (we && (int'(waddr) < DEPTH)) begin
      mem_d[int'(waddr)*WIDTH +: WIDTH] = wdata;
    end
    rd_d = '0;
    if (int'(raddr) < DEPTH) begin
      rd_d = all_q[int'(raddr)*WIDTH +: WIDTH];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      all_q <= '0;
      rdata <= '0;
    end else begin
      all_q <= mem_d;
      rdata <= rd_d;
    end
  end
endmodule

// file: hdl/cgp_gpio.sv
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
module cgp_gpio
  import cgp_pkg::*;
#(
  parameter int NPIN = NUM_PINS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPIN*NUM_SRC-1:0] src_out,
  input wire logic [NPIN*NUM_SRC-1:0] src_oe,
  input wire logic [NPIN-1:0] pad_in,
  input wire logic por_busy,
  input wire logic deep_sleep,
  output logic [NPIN-1:0] pad_out,
  output logic [NPIN-1:0] pad_oe,
  output logic [NPIN-1:0] pad_pu_strong,
  output logic [NPIN-1:0] pad_pu_weak,
  output logic [NPIN-1:0] pad_pd_strong,
  output logic [NPIN-1:0] pad_pd_weak,
  output logic [NPIN-1:0] pad_ie,
  output logic [NPIN-1:0] pad_lvttl,
  output logic [NPIN-1:0] pad_slow,
  output logic [NPIN-1:0] pad_amux,
  output logic [NPIN-1:0] pin_in
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACC = 2'b10
  } cgp_apb_t;

  localparam int AW = 5;

  cgp_apb_t st_q, st_d;
  logic [NPIN-1:0] out_q, out_d, inen_q, inen_d, outen_q, outen_d;
  logic [NPIN-1:0] thr_q, thr_d, slew_q, slew_d, hold_q, hold_d;
  logic [NPIN-1:0] amux_q, amux_d, i2c_q, i2c_d, in_q, in_d;
  logic [31:0] prdata_d;
  logic pslverr_d, pready_d;
  logic mode_we, sel_we;
  logic [AW-1:0] cfg_idx;
  logic [2:0] mode_rd, sel_rd;
  logic [NPIN*3-1:0] mode_all, sel_all, hm_q, hm_d;
  logic [NPIN-1:0] hout_q, hout_d, hoe_q, hoe_d;
  logic [NPIN-1:0] o_d, oe_d, pus_d, puw_d, pds_d, pdw_d, ie_d;
  logic [NPIN-1:0] lv_d, sl_d, am_d;
  logic force_off;
  logic wr_acc;

  function automatic logic [31:0] zext(input logic [NPIN-1:0] v);
    logic [31:0] r;
    r = '0;
    r[NPIN-1:0] = v;
    return r;
  endfunction

  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] base);
    return (a >= base) && (a < base + 12'(NPIN * 4));
  endfunction

  assign wr_acc = (st_q == ST_ACC) && psel && penable && pwrite;
  assign cfg_idx = 5'((paddr - (in_range(paddr, OFS_MODE0) ?
                   OFS_MODE0 : OFS_SEL0)) >> 2);
  assign mode_we = wr_acc && in_range(paddr, OFS_MODE0);
  assign sel_we = wr_acc && in_range(paddr, OFS_SEL0);

  // Drive mode per pin, zero code at reset
  cgp_cfg_mem #(.DEPTH(NPIN), .WIDTH(3), .AW(AW)) u_mode (
    .pclk(pclk), .presetn(presetn), .we(mode_we), .waddr(cfg_idx),
    .wdata(pwdata[2:0]), .raddr(cfg_idx), .rdata(mode_rd),
    .all_q(mode_all)
  );
  // Source select per pin
  cgp_cfg_mem #(.DEPTH(NPIN), .WIDTH(SRC_W), .AW(AW)) u_sel (
    .pclk(pclk), .presetn(presetn), .we(sel_we), .waddr(cfg_idx),
    .wdata(pwdata[SRC_W-1:0]), .raddr(cfg_idx), .rdata(sel_rd),
    .all_q(sel_all)
  );

  // APB slave, one wait state on every transfer
  always_comb begin
    st_d = st_q;
    out_d = out_q;
    inen_d = inen_q;
    outen_d = outen_q;
    thr_d = thr_q;
    slew_d = slew_q;
    hold_d = hold_q;
    amux_d = amux_q;
    i2c_d = i2c_q;
    prdata_d = prdata;
    pslverr_d = 1'b0;
    pready_d = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (psel && !penable) begin
          st_d = ST_ACC;
        end
      end
      ST_ACC: begin
        pready_d = 1'b1;
        st_d = ST_IDLE;
        prdata_d = '0;
        case (paddr)
          OFS_OUT: prdata_d = zext(out_q);
          OFS_IN: prdata_d = zext(in_q);
          OFS_INEN: prdata_d = zext(inen_q);
          OFS_OUTEN: prdata_d = zext(outen_q);
          OFS_THR: prdata_d = zext(thr_q);
          OFS_SLEW: prdata_d = zext(slew_q);
          OFS_HOLD: prdata_d = zext(hold_q);
          OFS_AMUX: prdata_d = zext(amux_q);
          OFS_I2C: prdata_d = zext(i2c_q);
          default: begin
            if (in_range(paddr, OFS_MODE0)) begin
              prdata_d = {29'h0, mode_rd};
            end else if (in_range(paddr, OFS_SEL0)) begin
              prdata_d = {29'h0, sel_rd};
            end else begin
              pslverr_d = 1'b1;
            end
          end
        endcase
        if (wr_acc) begin
          prdata_d = '0;
          case (paddr)
            OFS_OUT: out_d = pwdata[NPIN-1:0];
            OFS_INEN: inen_d = pwdata[NPIN-1:0];
            OFS_OUTEN: outen_d = pwdata[NPIN-1:0];
            OFS_THR: thr_d = pwdata[NPIN-1:0];
            OFS_SLEW: slew_d = pwdata[NPIN-1:0];
            OFS_HOLD: hold_d = pwdata[NPIN-1:0];
            OFS_AMUX: amux_d = pwdata[NPIN-1:0];
            OFS_I2C: i2c_d = pwdata[NPIN-1:0];
            default: pslverr_d = pslverr_d;
          endcase
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Pad control from mode, mux, hold and power state
  always_comb begin
    force_off = por_busy;
    in_d = pad_in & inen_q;
    hout_d = hout_q;
    hoe_d = hoe_q;
    hm_d = hm_q;
    o_d = '0;
    oe_d = '0;
    pus_d = '0;
    puw_d = '0;
    pds_d = '0;
    pdw_d = '0;
    ie_d = '0;
    lv_d = thr_q;
    sl_d = slew_q;
    am_d = amux_q;
    for (int i = 0; i < NPIN; i++) begin
      logic [2:0] m;
      logic [SRC_W-1:0] s;
      logic dv, de;
      m = mode_all[i*3 +: 3];
      s = sel_all[i*SRC_W +: SRC_W];
      dv = (s == '0) ? out_q[i] : src_out[i*NUM_SRC + int'(s)];
      de = outen_q[i] && ((s == '0) || src_oe[i*NUM_SRC + int'(s)]);
      if (i2c_q[i] && (m != DM_OD_STRONGUP)) begin
        m = DM_OD_STRONGDN;
      end
      if (hold_q[i]) begin
        dv = hout_q[i];
        de = hoe_q[i];
        m = hm_q[i*3 +: 3];
      end else begin
        hout_d[i] = dv;
        hoe_d[i] = de;
        hm_d[i*3 +: 3] = m;
      end
      ie_d[i] = inen_q[i];
      case (m)
        DM_INPUT_ONLY: begin
        end
        DM_WEAKUP_STRONGDN: begin
          puw_d[i] = de && dv;
          pds_d[i] = de && !dv;
        end
        DM_STRONGUP_WEAKDN: begin
          pus_d[i] = de && dv;
          pdw_d[i] = de && !dv;
        end
        DM_OD_STRONGDN: pds_d[i] = de && !dv;
        DM_OD_STRONGUP: pus_d[i] = de && dv;
        DM_STRONG: begin
          pus_d[i] = de && dv;
          pds_d[i] = de && !dv;
        end
        DM_WEAK: begin
          puw_d[i] = de && dv;
          pdw_d[i] = de && !dv;
        end
        default: begin
        end
      endcase
      o_d[i] = dv;
      oe_d[i] = pus_d[i] || pds_d[i];
    end
    if (force_off) begin
      oe_d = '0;
      pus_d = '0;
      puw_d = '0;
      pds_d = '0;
      pdw_d = '0;
      ie_d = '0;
      am_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      out_q <= '0;
      inen_q <= '0;
      outen_q <= '0;
      thr_q <= '0;
      slew_q <= '0;
      hold_q <= '0;
      amux_q <= '0;
      i2c_q <= '0;
      in_q <= '0;
      prdata <= RST_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
      hout_q <= '0;
      hoe_q <= '0;
      hm_q <= '0;
      pad_out <= '0;
      pad_oe <= '0;
      pad_pu_strong <= '0;
      pad_pu_weak <= '0;
      pad_pd_strong <= '0;
      pad_pd_weak <= '0;
      pad_ie <= '0;
      pad_lvttl <= '0;
      pad_slow <= '0;
      pad_amux <= '0;
      pin_in <= '0;
    end else begin
      st_q <= st_d;
      out_q <= out_d;
      inen_q <= inen_d;
      outen_q <= outen_d;
      thr_q <= thr_d;
      slew_q <= slew_d;
      hold_q <= hold_d;
      amux_q <= amux_d;
      i2c_q <= i2c_d;
      in_q <= in_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      hout_q <= hout_d;
      hoe_q <= hoe_d;
      hm_q <= hm_d;
      pad_out <= o_d;
      pad_oe <= oe_d;
      pad_pu_strong <= pus_d;
      pad_pu_weak <= puw_d;
      pad_pd_strong <= pds_d;
      pad_pd_weak <= pdw_d;
      pad_ie <= ie_d;
      pad_lvttl <= lv_d;
      pad_slow <= sl_d;
      pad_amux <= am_d;
      pin_in <= in_q;
    end
  end

  por_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    por_busy |=> (pad_oe == '0) && (pad_ie == '0))
    else $error("pad enabled during power-on");
  hold_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(hold_q) && (hold_q != '0) && !por_busy ##1 !por_busy
    |=> ((pad_out & hold_q) == ($past(pad_out) & hold_q)))
    else $error("held pin changed");
  od_i2c_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((pad_pu_strong & pad_pd_strong) == '0) &&
    (((pad_pu_weak | pad_pd_weak) & $past(i2c_q & ~hold_q)) == '0))
    else $error("i2c pin not open-drain");
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && st_q == ST_IDLE |=> ##1 pready)
    else $error("apb answer late");
  slew_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == OFS_SLEW |=> ##1
    pad_slow == $past(pwdata[NPIN-1:0], 2))
    else $error("slew not applied");
  thr_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == OFS_THR |=> ##1
    pad_lvttl == $past(pwdata[NPIN-1:0], 2))
    else $error("threshold not applied");
  amux_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    amux_q == '0 |=> pad_amux == '0)
    else $error("analog switch closed");
  input_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_all == '0) && (i2c_q == '0) && (hold_q == '0) |=> pad_oe == '0)
    else $error("input-only pin driven");
  sleep_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    deep_sleep && (hold_q != '0) ##1 !por_busy |=> por_busy ||
    ((pad_oe & hold_q) == ($past(pad_oe) & hold_q)))
    else $error("held drive lost in sleep");
endmodule

// file: bench/cgp_board.sv
`timescale 1ns/100ps
module cgp_board
  import cgp_pkg::*;
#(
  parameter int NPIN = NUM_PINS
) (
  input wire logic pclk,
  input wire logic [NPIN-1:0] pad_out,
  input wire logic [NPIN-1:0] pad_oe,
  input wire logic [NPIN-1:0] pad_pu_weak,
  input wire logic [NPIN-1:0] pad_pd_weak,
  output logic [NPIN-1:0] pad_in,
  output logic [NPIN*NUM_SRC-1:0] src_out,
  output logic [NPIN*NUM_SRC-1:0] src_oe
);
  logic flt_q = 1'b0;
  // Undriven pin wanders every cycle
  always_ff @(posedge pclk) begin
    flt_q <= ~flt_q;
  end
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      if (pad_oe[p]) begin
        pad_in[p] = pad_out[p];
      end else if (pad_pu_weak[p] | pad_pd_weak[p]) begin
        pad_in[p] = pad_pu_weak[p];
      end else begin
        pad_in[p] = flt_q ^ p[0];
      end
    end
    for (int i = 0; i < NPIN*NUM_SRC; i++) begin
      src_out[i] = (i % 3 == 0);
      src_oe[i] = (i % 4 != 0);
    end
  end
endmodule

// file: bench/test_cgp_gpio.sv
`timescale 1ns/100ps
module test_cgp_gpio;
  import cgp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic por_busy = 0, deep_sleep = 0, pready, pslverr, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  wire [NUM_PINS*NUM_SRC-1:0] src_out, src_oe;
  wire [NUM_PINS-1:0] pad_in;
  logic [NUM_PINS-1:0] pad_out, pad_oe, pus, puw, pds, pdw;
  logic [NUM_PINS-1:0] pad_ie, pad_lvttl, pad_slow, pad_amux, pin_in;
  logic [3:0] e;
  int n_errors = 0, comparisons = 0;
  cgp_gpio i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_out(src_out), .src_oe(src_oe), .pad_in(pad_in),
    .por_busy(por_busy), .deep_sleep(deep_sleep), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pu_strong(pus), .pad_pu_weak(puw),
    .pad_pd_strong(pds), .pad_pd_weak(pdw), .pad_ie(pad_ie),
    .pad_lvttl(pad_lvttl), .pad_slow(pad_slow), .pad_amux(pad_amux),
    .pin_in(pin_in));
  cgp_board i_board (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pu_weak(puw), .pad_pd_weak(pdw), .pad_in(pad_in),
    .src_out(src_out), .src_oe(src_oe));
  initial begin
    forever #5 pclk = ~pclk;
  end
  task automatic test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        n_errors++;
        test_done();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk(er, 0);
  endtask
  // Expected {pu_strong, pu_weak, pd_strong, pd_weak} per mode and value
  function automatic logic [3:0] drv(input logic [2:0] m, input logic v);
    case (m)
      DM_WEAKUP_STRONGDN: drv = v ? 4'h4 : 4'h2;
      DM_STRONGUP_WEAKDN: drv = v ? 4'h8 : 4'h1;
      DM_OD_STRONGDN: drv = v ? 4'h0 : 4'h2;
      DM_OD_STRONGUP: drv = v ? 4'h8 : 4'h0;
      DM_STRONG: drv = v ? 4'h8 : 4'h2;
      DM_WEAK: drv = v ? 4'h4 : 4'h1;
      default: drv = 4'h0;
    endcase
  endfunction
  task automatic pin0(input logic [3:0] exp);
    tick(2);
    chk({pus[0], puw[0], pds[0], pdw[0]}, exp);
    chk(pad_oe[0], exp[3] | exp[1]);
  endtask
  initial begin
    tick(8);
    chk(pad_oe | pus | pds | puw | pdw | pad_ie, 0);
    presetn <= 1'b1;
    for (int k = 0; k < 4; k++) rdc(OFS_OUT + 12'(4 * k), 0);
    rdc(OFS_MODE0 + 12'h04c, RST_MODE);
    wr(OFS_INEN, 32'hffff_a5a5);
    wr(OFS_THR, 32'hffff_a5a5);
    wr(OFS_SLEW, 32'hffff_a5a5);
    wr(OFS_AMUX, 32'hffff_a5a5);
    rdc(OFS_THR, 32'h000f_a5a5);
    tick(2);
    chk(pad_ie, 20'hfa5a5);
    chk(pad_lvttl, 20'hfa5a5);
    chk(pad_slow, 20'hfa5a5);
    chk(pad_amux, 20'hfa5a5);
    apb(1'b0, 12'h024, 0);
    chk(er, 1);
    chk(rd, 0);
    wr(OFS_OUTEN, 1);
    for (int m = 0; m < 8; m++) begin
      for (int v = 0; v < 2; v++) begin
        wr(OFS_MODE0, 32'(m));
        wr(OFS_OUT, 32'(v));
        e = drv(3'(m), 1'(v));
        pin0(e);
        tick(3);
        if (e != 0) chk(pin_in[0], e[3] | e[2]);
      end
      rdc(OFS_MODE0, 32'(m));
    end
    wr(OFS_MODE0, 32'(DM_STRONG));
    wr(OFS_OUTEN, 0);
    pin0(4'h0);
    wr(OFS_OUTEN, 1);
    for (int s = 1; s < 8; s++) begin
      wr(OFS_SEL0, 32'(s));
      tick(2);
      chk(pad_oe[0], 1'(s % 4 != 0));
      if (s % 4 != 0) chk(pad_out[0], 1'(s % 3 == 0));
    end
    wr(OFS_SEL0, 0);
    wr(OFS_I2C, 1);
    wr(OFS_OUT, 1);
    pin0(4'h0);
    wr(OFS_OUT, 0);
    pin0(4'h2);
    wr(OFS_I2C, 0);
    wr(OFS_OUT, 1);
    wr(OFS_HOLD, 1);
    deep_sleep <= 1'b1;
    wr(OFS_OUT, 0);
    wr(OFS_MODE0, 0);
    pin0(4'h8);
    chk(pad_out[0], 1);
    deep_sleep <= 1'b0;
    rdc(OFS_HOLD, 1);
    pin0(4'h8);
    wr(OFS_MODE0, 32'(DM_STRONG));
    wr(OFS_HOLD, 0);
    pin0(4'h2);
    por_busy <= 1'b1;
    tick(2);
    chk(pad_oe | pad_ie | pus | pds, 0);
    por_busy <= 1'b0;
    pin0(4'h2);
    presetn <= 1'b0;
    tick(2);
    chk(pad_oe | pad_ie | pad_slow | pad_amux, 0);
    presetn <= 1'b1;
    rdc(OFS_MODE0, 0);
    rdc(OFS_INEN, 0);
    test_done();
  end
endmodule
